// file: pbm_boot_select.v
// reset-time choice of gpio or address function for port b pins
`timescale 1ns/1ps
`default_nettype none
`include "pbm_consts.vh"
module pbm_boot_select #(
  parameter NPINS = `PBM_NPINS
) (
  input wire core_clk,
  input wire rst_n,
  input wire external_boot_select,
  input wire memMode,
  input wire flashSecure,
  output reg [NPINS-1:0] bootPer_q,
  output reg bootValid_q
);
  // straps are caught by a clocked process after release, never by reset itself
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bootPer_q <= {NPINS{1'b0}};
      bootValid_q <= 1'b0;
    end
    else if (!bootValid_q)
    begin
      bootValid_q <= 1'b1;
      // pins 0..3 only; secure flash forbids external boot exposure
      if ((external_boot_select || memMode) && !flashSecure)
        bootPer_q <= `PBM_BOOT_ADDR_MASK;
      else
        bootPer_q <= {NPINS{1'b0}};
    end
  end
endmodule
`default_nettype wire

// file: pbm_consts.vh
// register map, field positions and reset values of the port b pin mux
`ifndef PBM_CONSTS_VH
`define PBM_CONSTS_VH
`define PBM_NPINS 5
`define PBM_OFS_DATA 32'h0000_0000
`define PBM_OFS_DIR 32'h0000_0004
`define PBM_OFS_PER 32'h0000_0008
`define PBM_OFS_PUR 32'h0000_000c
`define PBM_OFS_BUSCTL 32'h0000_0010
`define PBM_OFS_PINS 32'h0000_0014
`define PBM_OFS_STATUS 32'h0000_0018
`define PBM_RST_DATA 5'h00
`define PBM_RST_DIR 5'h00
`define PBM_RST_PUR 5'h1f
`define PBM_RST_BUSCTL 1'h0
`define PBM_BIT_DRVKEEP 0
`define PBM_BIT_EXTERNAL_BOOT_SELECT 0
`define PBM_BIT_MEMMODE 1
`define PBM_BIT_SECURE 2
`define PBM_BIT_INIT 3
`define PBM_BOOT_ADDR_MASK 5'h0f
`define PBM_HTRANS_NONSEQ 2'h2
`define PBM_HTRANS_SEQ 2'h3
`endif

// file: pbm_ext_mem.sv
// external memory side: upper address source and pin levels
`timescale 1ns/1ps
`default_nettype none
module pbm_ext_mem (
  input wire logic core_clk,
  input wire logic busGo,
  input wire logic [4:0] padOut,
  input wire logic [4:0] padOe,
  input wire logic [4:0] padPullEn,
  output logic [4:0] extAddrHigh,
  output logic extBusActive,
  output logic [4:0] padIn
);
  logic flt_q = 1'h0;
  initial extAddrHigh = 5'h00;
  initial extBusActive = 1'h0;
  always @(posedge core_clk)
  begin
    extBusActive <= busGo;
    extAddrHigh <= extAddrHigh + 5'h0b;
    flt_q <= ~flt_q;
  end
  // undriven pin without pull-up toggles, never a stale level
  assign padIn = padOe & padOut | ~padOe & (padPullEn | {5{flt_q}});
endmodule
`default_nettype wire

// file: pbm_pad_cell.v
// per-pin output mux between gpio and address function
`timescale 1ns/1ps
`default_nettype none
module pbm_pad_cell (
  input wire core_clk,
  input wire rst_n,
  input wire perEn,
  input wire gpioDir,
  input wire gpioOut,
  input wire addrBit,
  input wire busActive,
  input wire driveKeep,
  input wire pullEn,
  output reg padOut_q,
  output reg padOe_q,
  output reg padPull_q
);
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      // gpio reads as input, address tri-stated during reset
      padOut_q <= 1'b0;
      padOe_q <= 1'b0;
      padPull_q <= 1'b1;
    end
    else
    begin
      if (perEn)
      begin
        padOut_q <= addrBit;
        padOe_q <= busActive | driveKeep;
      end
      else
      begin
        padOut_q <= gpioOut;
        padOe_q <= gpioDir;
      end
      // pull-up follows the previous cycle's output enable, so it goes off one cycle after the pin starts driving
      padPull_q <= pullEn & ~padOe_q;
    end
  end
endmodule
`default_nettype wire

// file: pbm_port_b_mux.v
// port b low pin mux: gpio or upper external address, with ahb-lite registers
// Contract
// - in gpio mode software sets each pin as input or output
// - in address mode each pin carries one upper external address line
// - address lines tri-state while bus idle unless drive-keep is set
// - during reset gpio is input and address is high impedance
// - after reset pins 0-3 pick function from boot, mode and security
// - writing peripheral-enable register switches pin function anytime
// - clearing a pull-up enable bit disables that pin's pull-up
// - each pin moves to peripheral function through its own enable bit
// - pull-up enable bit n controls port pin n
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pbm_consts.vh"
module pbm_port_b_mux #(
  parameter NPINS = `PBM_NPINS
) (
  input wire core_clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire external_boot_select,
  input wire memMode,
  input wire flashSecure,
  input wire [NPINS-1:0] extAddrHigh,
  input wire extBusActive,
  input wire [NPINS-1:0] padIn,
  output wire [NPINS-1:0] padOut,
  output wire [NPINS-1:0] padOe,
  output wire [NPINS-1:0] padPullEn,
  output reg busDriveKeep_q
);
  reg [NPINS-1:0] gpioData_q;
  reg [NPINS-1:0] gpioDir_q;
  reg [NPINS-1:0] perEn_q;
  reg [NPINS-1:0] pullEn_q;
  reg [NPINS-1:0] padInReg_q;
  reg wrPend_q;
  reg [31:0] wrAddr_q;
  reg [31:0] rdData_d;
  reg perLoaded_q;
  wire [NPINS-1:0] bootPer;
  wire bootValid;
  wire acc;

  function [NPINS-1:0] wlow;
    input [31:0] w;
    begin
      wlow = w[NPINS-1:0];
    end
  endfunction

  assign acc = hsel && hready && (htrans == `PBM_HTRANS_NONSEQ || htrans == `PBM_HTRANS_SEQ);

  pbm_boot_select #(.NPINS(NPINS)) uBoot (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .external_boot_select(external_boot_select),
    .memMode(memMode),
    .flashSecure(flashSecure),
    .bootPer_q(bootPer),
    .bootValid_q(bootValid)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1)
    begin : gPad
      pbm_pad_cell uPad (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .perEn(perEn_q[gi]),
        .gpioDir(gpioDir_q[gi]),
        .gpioOut(gpioData_q[gi]),
        .addrBit(extAddrHigh[gi]),
        .busActive(extBusActive),
        .driveKeep(busDriveKeep_q),
        .pullEn(pullEn_q[gi]),
        .padOut_q(padOut[gi]),
        .padOe_q(padOe[gi]),
        .padPull_q(padPullEn[gi])
      );
    end
  endgenerate

  // registers; write data lands one cycle after the address phase
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      gpioData_q <= `PBM_RST_DATA;
      gpioDir_q <= `PBM_RST_DIR;
      perEn_q <= {NPINS{1'b0}};
      pullEn_q <= `PBM_RST_PUR;
      busDriveKeep_q <= `PBM_RST_BUSCTL;
      padInReg_q <= {NPINS{1'b0}};
      wrPend_q <= 1'b0;
      wrAddr_q <= 32'h0000_0000;
      perLoaded_q <= 1'b0;
    end
    else
    begin
      padInReg_q <= padIn;
      wrPend_q <= acc && hwrite;
      if (acc)
        wrAddr_q <= haddr;
      // boot choice loads once; a software write in the same cycle wins
      if (bootValid && !perLoaded_q)
      begin
        perLoaded_q <= 1'b1;
        perEn_q <= bootPer;
      end
      if (wrPend_q)
      begin
        case (wrAddr_q)
          `PBM_OFS_DATA: gpioData_q <= wlow(hwdata);
          `PBM_OFS_DIR: gpioDir_q <= wlow(hwdata);
          `PBM_OFS_PER: perEn_q <= wlow(hwdata);
          `PBM_OFS_PUR: pullEn_q <= wlow(hwdata);
          `PBM_OFS_BUSCTL: busDriveKeep_q <= hwdata[`PBM_BIT_DRVKEEP];
          default: gpioData_q <= gpioData_q;
        endcase
      end
    end
  end

  always @*
  begin
    rdData_d = 32'h0000_0000;
    case (haddr)
      `PBM_OFS_DATA: rdData_d[NPINS-1:0] = gpioData_q;
      `PBM_OFS_DIR: rdData_d[NPINS-1:0] = gpioDir_q;
      `PBM_OFS_PER: rdData_d[NPINS-1:0] = perEn_q;
      `PBM_OFS_PUR: rdData_d[NPINS-1:0] = pullEn_q;
      `PBM_OFS_BUSCTL: rdData_d[`PBM_BIT_DRVKEEP] = busDriveKeep_q;
      `PBM_OFS_PINS: rdData_d[NPINS-1:0] = padInReg_q;
      `PBM_OFS_STATUS:
      begin
        rdData_d[`PBM_BIT_EXTERNAL_BOOT_SELECT] = external_boot_select;
        rdData_d[`PBM_BIT_MEMMODE] = memMode;
        rdData_d[`PBM_BIT_SECURE] = flashSecure;
        rdData_d[`PBM_BIT_INIT] = perLoaded_q;
      end
      default: rdData_d = 32'h0000_0000;
    endcase
  end

  // zero wait states; unmapped reads give zero, unmapped writes are dropped
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (acc && !hwrite)
        hrdata <= rdData_d;
    end
  end
endmodule
`default_nettype wire

// file: pbm_port_b_mux_properties.sv
// checker for the port b pin mux
`timescale 1ns/1ps
`default_nettype none
module pbm_port_b_mux_properties #(parameter NPINS = 5) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [NPINS-1:0] extAddrHigh,
  input wire logic extBusActive,
  input wire logic [NPINS-1:0] padOut,
  input wire logic [NPINS-1:0] padOe,
  input wire logic [NPINS-1:0] padPullEn,
  input wire logic busDriveKeep_q
);
  logic [31:0] adr_q;
  logic wr_q, kn_q;
  logic [NPINS-1:0] per_q, dir_q, dat_q;
  wire [NPINS-1:0] oe = {NPINS{extBusActive | busDriveKeep_q}};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // shadows from observed writes; one slave, so no select needed
  always_ff @(posedge core_clk)
  begin
    wr_q <= rst_n && htrans[1] && hwrite;
    adr_q <= haddr;
    kn_q <= rst_n && (kn_q || wr_q && adr_q == 32'h8);
    dir_q <= !rst_n ? '0 : wr_q && adr_q == 32'h4 ? hwdata[NPINS-1:0] : dir_q;
    dat_q <= !rst_n ? '0 : wr_q && adr_q == 32'h0 ? hwdata[NPINS-1:0] : dat_q;
    if (wr_q && adr_q == 32'h8) per_q <= hwdata[NPINS-1:0];
  end
  a_reset_idle: assert property ($rose(rst_n) |-> (padOe | padOut) == 0)
    else $error("pads active out of reset");
  a_reset_pullup: assert property ($rose(rst_n) |-> &padPullEn)
    else $error("pull-ups off out of reset");
  a_gpio_dir: assert property (kn_q |=> ((padOe ^ $past(dir_q)) & ~$past(per_q)) == 0)
    else $error("gpio direction wrong");
  a_gpio_data: assert property (kn_q |=> ((padOut ^ $past(dat_q)) & ~$past(per_q)) == 0)
    else $error("gpio data wrong");
  a_addr_line: assert property (kn_q |=> ((padOut ^ $past(extAddrHigh)) & $past(per_q)) == 0)
    else $error("address line wrong");
  a_addr_tristate: assert property (kn_q |=> ((padOe ^ $past(oe)) & $past(per_q)) == 0)
    else $error("address enable wrong");
  a_pull_driven: assert property (rst_n |=> (padPullEn & $past(padOe)) == 0)
    else $error("pull-up on driven pin");
  a_keep_write: assert property (wr_q && adr_q == 32'h10 |=> busDriveKeep_q == $past(hwdata[0]))
    else $error("drive-keep not written");
endmodule
bind pbm_port_b_mux pbm_port_b_mux_properties #(.NPINS(NPINS)) u_props (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .extAddrHigh(extAddrHigh),
  .extBusActive(extBusActive),
  .padOut(padOut),
  .padOe(padOe),
  .padPullEn(padPullEn),
  .busDriveKeep_q(busDriveKeep_q)
);
`default_nettype wire

// file: pbm_port_b_mux_tb_top.sv
// testbench for the port b pin mux
`timescale 1ns/1ps
`default_nettype none
`include "pbm_consts.vh"
module pbm_port_b_mux_tb_top;
  logic core_clk = '0, rst_n = '0, hsel = '0, hwrite = '0, busGo = '0;
  logic external_boot_select = '0, memMode = '0, flashSecure = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, rd;
  logic [2:0] straps [4] = '{3'h1, 3'h2, 3'h5, 3'h0};
  wire [31:0] hrdata;
  wire hreadyout, hresp, busDriveKeep_q, extBusActive;
  wire hready = hreadyout;
  wire [4:0] extAddrHigh, padIn, padOut, padOe, padPullEn;
  int error_cnt = 0, num_checks = 0;
  always #20 core_clk = ~core_clk;
  pbm_port_b_mux u_pbm_port_b_mux (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .external_boot_select(external_boot_select),
    .memMode(memMode),
    .flashSecure(flashSecure),
    .extAddrHigh(extAddrHigh),
    .extBusActive(extBusActive),
    .padIn(padIn),
    .padOut(padOut),
    .padOe(padOe),
    .padPullEn(padPullEn),
    .busDriveKeep_q(busDriveKeep_q)
  );
  pbm_ext_mem u_pbm_ext_mem (
    .core_clk(core_clk),
    .busGo(busGo),
    .padOut(padOut),
    .padOe(padOe),
    .padPullEn(padPullEn),
    .extAddrHigh(extAddrHigh),
    .extBusActive(extBusActive),
    .padIn(padIn)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= `PBM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic rst(input logic [2:0] s);
    rst_n <= 1'h0;
    {flashSecure, memMode, external_boot_select} <= s;
    repeat (3) @(posedge core_clk);
    chk(padOe, 32'h0);
    rst_n <= 1'h1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic pads(input logic [31:0] exp);
    repeat (3) @(posedge core_clk);
    chk(padOe, exp);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    foreach (straps[i])
    begin
      rst(straps[i]);
      xfer(1'h0, `PBM_OFS_PER, 32'h0);
      chk(rd, (straps[i][0] | straps[i][1]) & ~straps[i][2] ? 32'hf : 32'h0);
    end
    xfer(1'h0, `PBM_OFS_STATUS, 32'h0);
    chk(rd, 32'h8);
    xfer(1'h0, `PBM_OFS_PUR, 32'h0);
    chk(rd, 32'h1f);
    xfer(1'h1, `PBM_OFS_PER, 32'h0);
    xfer(1'h1, `PBM_OFS_DIR, 32'hf);
    xfer(1'h1, `PBM_OFS_DATA, 32'ha);
    pads(32'hf);
    xfer(1'h0, `PBM_OFS_PINS, 32'h0);
    chk(rd, 32'h1a);
    xfer(1'h1, `PBM_OFS_PER, 32'h11);
    pads(32'he);
    busGo <= 1'h1;
    pads(32'h1f);
    busGo <= 1'h0;
    pads(32'he);
    xfer(1'h1, `PBM_OFS_BUSCTL, 32'h1);
    pads(32'h1f);
    xfer(1'h0, `PBM_OFS_BUSCTL, 32'h0);
    chk(rd, 32'h1);
    chk(busDriveKeep_q, 32'h1);
    xfer(1'h1, `PBM_OFS_PER, 32'h0);
    xfer(1'h1, `PBM_OFS_DIR, 32'h0);
    xfer(1'h1, `PBM_OFS_PUR, 32'hf);
    repeat (3) @(posedge core_clk);
    chk(padPullEn, 32'hf);
    stop_test;
  end
  initial
  begin
    #100000;
    error_cnt++;
    stop_test;
  end
endmodule
`default_nettype wire
